/* wd_sync_pulse.v */
/*
  Carries a watchdog clock level into the MCLK domain and marks each rising edge.
  Assumes the watchdog clock is at most a quarter of MCLK.
*/
`timescale 1ns/1ps

module wd_sync_pulse
(
  // clock and reset
  input  wire MCLK,
  input  wire RSTN,
  // asynchronous level
  input  wire async_in,
  // one-cycle rising-edge mark
  output wire rise
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edge seen only past the second stage
  assign rise = s2_q & ~s3_q;

endmodule // wd_sync_pulse

/* windowed_watchdog.v */
/*
  Windowed watchdog: 24-bit down-counter behind a divide-by-4 prescaler, feed checking,
  window, warning, chip reset request and wake request.
  Assumes the oscillator clocks arrive as pins slower than MCLK/4; the reset request
  is combined with pin, power-on and brownout resets outside this block.
*/
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "windowed_watchdog_defines.vh"

// Notes on behaviour
// - counter reaching zero without reload forces a chip-wide reset; here only with reset mode set, otherwise an interrupt
// - in window mode a feed is valid only while count is below window value; the code also accepts count equal to it
// - warning interrupt when count equals programmed warning point
// - enable set by software only; cleared by reset or watchdog event
// - bad feed sequence is a fault: reset, or interrupt in interrupt mode
// - flag records that watchdog caused the reset; readable by software
// - 24-bit programmable counter clocked by watchdog clock divided by four
// - time-out from 256 x 4 to 2^24 x 4 periods, steps of four
// - watchdog clock selectable between internal RC and watchdog oscillator
// - in deep sleep internal RC gated off unless selected for watchdog
// - watchdog oscillator may keep running in deep sleep for wake-up
// - in power-down only the selected watchdog oscillator keeps running
// - watchdog interrupt wakes chip from deep sleep and power-down
// - watchdog reset is one of four chip reset sources
module windowed_watchdog
#(
  parameter CW = 24
)
(
  // clock and reset
  input  wire          MCLK,
  input  wire          RSTN,
  // register port
  input  wire [7:0]    ADDR,
  input  wire [31:0]   WDATA,
  input  wire          WR,
  input  wire          RD,
  output reg  [31:0]   RDATA,
  // oscillator clocks, asynchronous pins
  input  wire          INTERNAL_RC_OSCILLATOR,
  input  wire          WATCHDOG_OSCILLATOR,
  // power state from power control
  input  wire          DEEP_SLEEP,
  input  wire          POWER_DOWN,
  // reset cause of the last chip reset, held by the system through RSTN and the first cycle after it releases
  input  wire          WATCHDOG_RESET_SEEN,
  // results
  output reg           CHIP_RESET_REQ,
  output wire          WATCHDOG_IRQ,
  output wire          WAKE_REQ,
  output wire          INTERNAL_RC_OSCILLATOR_EN,
  output wire          WATCHDOG_OSCILLATOR_EN
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg            en_q;
  reg            reset_mode_q;
  reg            win_en_q;
  reg            running_q;
  reg            to_flag_q;
  reg            warn_flag_q;
  reg            fault_q;
  reg            wdreset_flag_q;
  reg            cause_cap_q;
  reg [CW-1:0]   timeout_q;
  reg [CW-1:0]   window_q;
  reg [9:0]      warn_q;
  reg            clksel_q;
  reg [CW-1:0]   count_q;
  reg [`WD_PRESCALE_W-1:0] pre_q;
  reg            feed_armed_q;

  wire           osc_rise;
  wire           tick;
  wire           sel_clk;
  wire           feed_wr;
  wire           feed_ok1;
  wire           feed_ok2;
  wire           feed_bad;
  wire           in_window;
  wire           valid_feed;
  wire           expire;
  wire           warn_hit;
  wire [CW-1:0]  to_wr;

  // ----------------------------------------------------------------
  // clock source
  // ----------------------------------------------------------------
  // source select mux
  assign sel_clk = clksel_q ? WATCHDOG_OSCILLATOR : INTERNAL_RC_OSCILLATOR;

  // rc gated in deep sleep unless selected
  assign INTERNAL_RC_OSCILLATOR_EN = ~POWER_DOWN & (~DEEP_SLEEP | ~clksel_q);
  // watchdog oscillator kept in deep sleep and power-down only when selected
  assign WATCHDOG_OSCILLATOR_EN = ~(DEEP_SLEEP | POWER_DOWN) | clksel_q;

  wd_sync_pulse i_wd_sync_pulse
  (
    .MCLK     (MCLK),
    .RSTN     (RSTN),
    .async_in (sel_clk),
    .rise     (osc_rise)
  );

  assign tick = osc_rise & (pre_q == (`WD_PRESCALE - 1));

  // ----------------------------------------------------------------
  // feed decode
  // ----------------------------------------------------------------
  assign feed_wr  = WR & (ADDR == `WD_ADDR_FEED);
  assign feed_ok1 = feed_wr & (WDATA[7:0] == `WD_FEED_FIRST);
  assign feed_ok2 = feed_wr & feed_armed_q & (WDATA[7:0] == `WD_FEED_SECOND);
  // broken sequence: second byte wrong, or register write between bytes
  assign feed_bad = running_q & feed_armed_q & WR & ~feed_ok2;
  // window check, off when window mode clear
  assign in_window  = ~win_en_q | (count_q <= window_q);
  assign valid_feed = feed_ok2 & in_window;
  assign expire   = running_q & tick & (count_q == {CW{1'b0}});
  assign warn_hit = running_q & (count_q == {{(CW-10){1'b0}}, warn_q});
  assign to_wr = (WDATA[CW-1:0] < `WD_TIMEOUT_MIN) ? `WD_TIMEOUT_MIN : WDATA[CW-1:0];

  // ----------------------------------------------------------------
  // counter and control
  // ----------------------------------------------------------------
  always @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      en_q         <= 1'b0;
      reset_mode_q <= 1'b0;
      win_en_q     <= 1'b0;
      running_q    <= 1'b0;
      to_flag_q    <= 1'b0;
      warn_flag_q  <= 1'b0;
      fault_q      <= 1'b0;
      timeout_q    <= `WD_TIMEOUT_RST;
      window_q     <= `WD_WINDOW_RST;
      warn_q       <= `WD_WARN_RST;
      clksel_q     <= 1'b0;
      count_q      <= `WD_TIMEOUT_RST;
      pre_q        <= {`WD_PRESCALE_W{1'b0}};
      feed_armed_q <= 1'b0;
      CHIP_RESET_REQ <= 1'b0;
    end
    else
    begin
      if (osc_rise)
        pre_q <= pre_q + 1'b1;
      if (feed_ok1)
        feed_armed_q <= 1'b1;
      else if (WR)
        feed_armed_q <= 1'b0;

      if (WR && ADDR == `WD_ADDR_MODE)
      begin
        // enable and reset mode are set-only
        if (WDATA[`WD_MODE_EN])
          en_q <= 1'b1;
        if (WDATA[`WD_MODE_RESET])
          reset_mode_q <= 1'b1;
        win_en_q <= WDATA[`WD_MODE_WINEN];
      end
      if (WR && ADDR == `WD_ADDR_TIMEOUT)
        timeout_q <= to_wr;
      if (WR && ADDR == `WD_ADDR_WINDOW)
        window_q <= WDATA[CW-1:0];
      if (WR && ADDR == `WD_ADDR_WARN)
        warn_q <= WDATA[9:0];
      // clock choice frozen once running
      if (WR && ADDR == `WD_ADDR_CLKSEL && !running_q)
        clksel_q <= WDATA[0];

      // flags clear by writing one; a set in the same cycle wins
      if (WR && ADDR == `WD_ADDR_MODE && WDATA[`WD_MODE_WARNFLAG])
        warn_flag_q <= 1'b0;
      if (warn_hit)
        warn_flag_q <= 1'b1;
      if (WR && ADDR == `WD_ADDR_MODE && WDATA[`WD_MODE_TOFLAG])
        to_flag_q <= 1'b0;
      if (WR && ADDR == `WD_ADDR_MODE && WDATA[`WD_MODE_FAULT])
        fault_q <= 1'b0;

      // counting starts on first valid feed after enable
      if (en_q && valid_feed)
      begin
        running_q <= 1'b1;
        count_q   <= timeout_q;
        pre_q     <= {`WD_PRESCALE_W{1'b0}};
      end
      else if (expire || feed_bad || (feed_ok2 && !in_window))
      begin
        running_q <= 1'b0;
        en_q      <= 1'b0;
        to_flag_q <= 1'b1;
        fault_q   <= feed_bad | (feed_ok2 & ~in_window);
        if (reset_mode_q)
          CHIP_RESET_REQ <= 1'b1;
      end
      else if (running_q && tick)
        count_q <= count_q - 1'b1;
    end
  end

  always @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      cause_cap_q    <= 1'b0;
      wdreset_flag_q <= 1'b0;
    end
    else
    begin
      cause_cap_q <= 1'b1;
      if (!cause_cap_q)
        wdreset_flag_q <= WATCHDOG_RESET_SEEN;
      else if (WR && ADDR == `WD_ADDR_CLKSEL && WDATA[8])
        wdreset_flag_q <= 1'b0;
    end
  end

  assign WATCHDOG_IRQ = ~reset_mode_q & (to_flag_q | fault_q) | warn_flag_q;
  // wake from deep sleep and power-down
  assign WAKE_REQ = WATCHDOG_IRQ & (DEEP_SLEEP | POWER_DOWN);

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @(posedge MCLK)
  begin
    if (!RSTN)
      RDATA <= 32'h00000000;
    else if (RD)
    begin
      case (ADDR)
        `WD_ADDR_MODE:
          RDATA <= {26'h0, win_en_q, fault_q, warn_flag_q, to_flag_q, reset_mode_q, en_q};
        `WD_ADDR_TIMEOUT:
          RDATA <= {{(32-CW){1'b0}}, timeout_q};
        `WD_ADDR_COUNT:
          RDATA <= {{(32-CW){1'b0}}, count_q};
        `WD_ADDR_CLKSEL:
          RDATA <= {23'h0, wdreset_flag_q, 7'h0, clksel_q};
        `WD_ADDR_WARN:
          RDATA <= {22'h0, warn_q};
        `WD_ADDR_WINDOW:
          RDATA <= {{(32-CW){1'b0}}, window_q};
        default:
          RDATA <= 32'h00000000;
      endcase
    end
    else
      RDATA <= 32'h00000000;
  end

endmodule // windowed_watchdog

/* windowed_watchdog_chk.sv */
/*
  Port checker for the windowed watchdog.
  Assumes it is bound to every windowed_watchdog instance.
*/
`timescale 1ns/1ps
`include "windowed_watchdog_defines.vh"

module windowed_watchdog_chk
#(
  parameter CW = 24
)
(
  input wire        MCLK,
  input wire        RSTN,
  input wire [7:0]  ADDR,
  input wire        RD,
  input wire [31:0] RDATA,
  input wire        DEEP_SLEEP,
  input wire        POWER_DOWN,
  input wire        CHIP_RESET_REQ,
  input wire        WATCHDOG_IRQ,
  input wire        WAKE_REQ,
  input wire        INTERNAL_RC_OSCILLATOR_EN
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  sequence s_rd(logic [7:0] a);
    RD && ADDR == a;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (s_rd(8'h20) |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_timeout_range: assert property (s_rd(`WD_ADDR_TIMEOUT) |=> RDATA <= 32'hFFFFFF && RDATA >= 32'hFF)
    else $error("time-out value out of range");
  a_count_width: assert property (s_rd(`WD_ADDR_COUNT) |=> RDATA[31:24] == 8'h0)
    else $error("count wider than 24 bits");
  a_warn_width: assert property (s_rd(`WD_ADDR_WARN) |=> RDATA[31:10] == 22'h0)
    else $error("warning point wider than 10 bits");
  a_wake_gate: assert property (WAKE_REQ == (WATCHDOG_IRQ && (DEEP_SLEEP || POWER_DOWN)))
    else $error("wake request wrong");
  a_reset_sticky: assert property (CHIP_RESET_REQ |=> CHIP_RESET_REQ)
    else $error("chip reset request dropped");
  a_pd_rc_off: assert property (POWER_DOWN |-> !INTERNAL_RC_OSCILLATOR_EN)
    else $error("rc oscillator on in power-down");
  a_run_rc_on: assert property (!DEEP_SLEEP && !POWER_DOWN |-> INTERNAL_RC_OSCILLATOR_EN)
    else $error("rc oscillator off while awake");
endmodule // windowed_watchdog_chk

bind windowed_watchdog windowed_watchdog_chk #(.CW(CW)) i_chk (.MCLK(MCLK), .RSTN(RSTN),
  .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .DEEP_SLEEP(DEEP_SLEEP), .POWER_DOWN(POWER_DOWN),
  .CHIP_RESET_REQ(CHIP_RESET_REQ), .WATCHDOG_IRQ(WATCHDOG_IRQ), .WAKE_REQ(WAKE_REQ),
  .INTERNAL_RC_OSCILLATOR_EN(INTERNAL_RC_OSCILLATOR_EN));

/* windowed_watchdog_defines.vh */
/*
  Register offsets, field positions, reset values and timing constants for the windowed watchdog.
  Assumes inclusion by bare name from the watchdog design files.
*/
`ifndef WINDOWED_WATCHDOG_DEFINES_VH
`define WINDOWED_WATCHDOG_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define WD_ADDR_MODE      8'h00
`define WD_ADDR_TIMEOUT   8'h04
`define WD_ADDR_FEED      8'h08
`define WD_ADDR_COUNT     8'h0C
`define WD_ADDR_CLKSEL    8'h10
`define WD_ADDR_WARN      8'h14
`define WD_ADDR_WINDOW    8'h18

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define WD_MODE_EN        0
`define WD_MODE_RESET     1
`define WD_MODE_TOFLAG    2
`define WD_MODE_WARNFLAG  3
`define WD_MODE_FAULT     4
`define WD_MODE_WINEN     5

// ----------------------------------------------------------------
// reset values, feed codes and timing constants
// ----------------------------------------------------------------
`define WD_TIMEOUT_RST    24'hFFFFFF
`define WD_TIMEOUT_MIN    24'h0000FF
`define WD_WARN_RST       10'h000
`define WD_WINDOW_RST     24'hFFFFFF
`define WD_FEED_FIRST     8'hAA
`define WD_FEED_SECOND    8'h55
`define WD_PRESCALE       4
`define WD_PRESCALE_W     2

`endif

/* windowed_watchdog_tb.sv */
/*
  Self-checking bench for the windowed watchdog.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "windowed_watchdog_defines.vh"

module windowed_watchdog_tb;
  reg          mclk = 1'b0;
  reg          rstn = 1'b0;
  reg  [7:0]   addr = 8'h00;
  reg  [31:0]  wdata = 32'h0;
  reg          wr = 1'b0;
  reg          rd = 1'b0;
  reg          rc_osc = 1'b0;
  reg          wdo_osc = 1'b0;
  reg          dsleep = 1'b0;
  reg          pdown = 1'b0;
  reg          seen = 1'b0;
  reg          rd_seen = 1'b0;
  wire [31:0]  rdata;
  wire         reset_req, irq, wake, rc_en, wdo_en;
  integer      n_mismatch = 0;
  integer      n_checks = 0;
  integer      n;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [31:0] r;

  always #5 mclk = ~mclk;
  // two unrelated oscillators, both well under a quarter of mclk
  always #40 rc_osc = ~rc_osc;
  always #37 wdo_osc = ~wdo_osc;

  windowed_watchdog i_windowed_watchdog (.MCLK(mclk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .INTERNAL_RC_OSCILLATOR(rc_osc),
    .WATCHDOG_OSCILLATOR(wdo_osc), .DEEP_SLEEP(dsleep), .POWER_DOWN(pdown),
    .WATCHDOG_RESET_SEEN(seen), .CHIP_RESET_REQ(reset_req), .WATCHDOG_IRQ(irq),
    .WAKE_REQ(wake), .INTERNAL_RC_OSCILLATOR_EN(rc_en), .WATCHDOG_OSCILLATOR_EN(wdo_en));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_checks++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      addr <= a; wdata <= d; wr <= 1'b1; rd <= 1'b0;
      @(posedge mclk);
    end
  endtask

  task rd_reg(input [7:0] a, input [31:0] e, input [31:0] m);
    begin
      eq.push_back(e); mq.push_back(m);
      addr <= a; rd <= 1'b1; wr <= 1'b0;
      @(posedge mclk);
    end
  endtask

  task idle(input integer k);
    begin
      wr <= 1'b0; rd <= 1'b0;
      repeat (k) @(posedge mclk);
    end
  endtask

  task feed;
    begin
      wr_reg(`WD_ADDR_FEED, 32'hAA);
      wr_reg(`WD_ADDR_FEED, 32'h55);
    end
  endtask

  task do_reset(input logic s, input integer k);
    begin
      rstn <= 1'b0; seen <= s; wr <= 1'b0; rd <= 1'b0;
      repeat (k) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      seen <= 1'b0;
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // read data stand only in the cycle after the read strobe
  always @(posedge mclk)
  begin
    rd_seen <= rd;
    if (rd_seen)
      chk(rdata & mq.pop_front(), eq.pop_front());
  end

  initial
  begin
    #400000;
    n_mismatch++;
    give_verdict;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    r = $urandom(75457);
    do_reset(1'b0, 8);
    rd_reg(`WD_ADDR_TIMEOUT, 32'hFFFFFF, 32'hFFFFFFFF);
    rd_reg(`WD_ADDR_COUNT, 32'hFFFFFF, 32'hFFFFFFFF);
    rd_reg(`WD_ADDR_MODE, 32'h0, 32'hFFFFFFFF);
    rd_reg(8'h20, 32'h0, 32'hFFFFFFFF);
    wr_reg(`WD_ADDR_TIMEOUT, 32'h10);
    rd_reg(`WD_ADDR_TIMEOUT, 32'hFF, 32'hFFFFFFFF);
    r = $urandom;
    wr_reg(`WD_ADDR_WARN, r);
    rd_reg(`WD_ADDR_WARN, r & 32'h3FF, 32'hFFFFFFFF);
    r = $urandom;
    wr_reg(`WD_ADDR_WINDOW, r);
    rd_reg(`WD_ADDR_WINDOW, r & 32'hFFFFFF, 32'hFFFFFFFF);
    wr_reg(`WD_ADDR_TIMEOUT, 32'hFFFFFF);
    // enable cannot be cleared by a write
    wr_reg(`WD_ADDR_MODE, 32'h1);
    wr_reg(`WD_ADDR_MODE, 32'h0);
    rd_reg(`WD_ADDR_MODE, 32'h1, 32'h1);
    feed;
    rd_reg(`WD_ADDR_COUNT, 32'hFFFF00, 32'hFFFF00);
    // broken feed pair, interrupt mode
    wr_reg(`WD_ADDR_FEED, 32'hAA);
    wr_reg(`WD_ADDR_FEED, 32'h11);
    idle(1);
    rd_reg(`WD_ADDR_MODE, 32'h10, 32'h10);
    idle(2);
    chk(irq, 1'b1);
    dsleep <= 1'b1;
    idle(2);
    chk(wake, 1'b1);
    chk(rc_en, 1'b1);
    dsleep <= 1'b0;
    // reset cause remembered and cleared
    do_reset(1'b1, 2);
    rd_reg(`WD_ADDR_CLKSEL, 32'h100, 32'h100);
    wr_reg(`WD_ADDR_CLKSEL, 32'h100);
    rd_reg(`WD_ADDR_CLKSEL, 32'h0, 32'h100);
    // window mode: feed too early is a fault, feed inside window starts counting
    wr_reg(`WD_ADDR_WINDOW, 32'h100);
    wr_reg(`WD_ADDR_MODE, 32'h21);
    feed;
    rd_reg(`WD_ADDR_MODE, 32'h10, 32'h11);
    wr_reg(`WD_ADDR_MODE, 32'h1C);
    wr_reg(`WD_ADDR_WINDOW, 32'hFFFFFF);
    wr_reg(`WD_ADDR_MODE, 32'h21);
    feed;
    rd_reg(`WD_ADDR_MODE, 32'h21, 32'h31);
    do_reset(1'b0, 2);
    // shortest time-out on the dedicated oscillator, reset mode, in power-down
    wr_reg(`WD_ADDR_CLKSEL, 32'h1);
    wr_reg(`WD_ADDR_TIMEOUT, 32'h0);
    wr_reg(`WD_ADDR_MODE, 32'h3);
    feed;
    pdown <= 1'b1;
    idle(2);
    chk(wdo_en, 1'b1);
    n = 0;
    while (reset_req !== 1'b1 && n < 12000)
    begin
      idle(1);
      n++;
    end
    chk(reset_req, 1'b1);
    rd_reg(`WD_ADDR_MODE, 32'h4, 32'h4);
    idle(2);
    give_verdict;
  end
endmodule // windowed_watchdog_tb
